// ==== hw/eth_port_pkg.sv ====
/*
 * Shared constants for the Ethernet port pin block: interface modes,
 * clock rates, lane widths and the false-carrier pattern.
 * Assumes a 100 MHz system clock and a separate transmit link clock.
 */
package eth_port_pkg;

  // ****************************************
  // Interface modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_MII,
    MODE_GMII,
    MODE_RMII,
    MODE_TBI
  } port_mode_t;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned TX_CLOCK_100M_HZ = 25_000_000;
  localparam int unsigned TX_CLOCK_HALF_CYCLES = SYS_CLK_HZ / (2 * TX_CLOCK_100M_HZ);

  // ****************************************
  // Data lanes and words
  // ****************************************
  localparam int unsigned TX_BUS_W = 8;
  localparam int unsigned TX_WORD_W = 9;
  localparam int unsigned TBI_ENABLE_BIT = 8;
  localparam int unsigned MII_LANE_W = 4;
  localparam int unsigned RMII_LANE_W = 2;
  localparam logic [2:0] SYMS_GMII = 3'h1;
  localparam logic [2:0] SYMS_MII = 3'h2;
  localparam logic [2:0] SYMS_RMII = 3'h4;

  // ****************************************
  // Receive decode
  // ****************************************
  localparam logic [7:0] FALSE_CARRIER_CODE = 8'h0e;
  localparam logic [7:0] MASK_GMII = 8'hff;
  localparam logic [7:0] MASK_MII = 8'h0f;
  localparam logic [7:0] MASK_RMII = 8'h03;

endpackage : eth_port_pkg

// ==== hw/sync_2ff.sv ====
/*
 * Two-flop level synchroniser, WIDTH bits wide.
 * Assumes each bit is a level that stays put long enough to be seen;
 * multi-bit use only for static or slow quantities.
 */
module sync_2ff #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // Elaboration check on width
  if (WIDTH < 1) begin : g_bad_width
    $error("sync_2ff needs WIDTH of at least 1");
  end

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : sync_2ff

// ==== hw/eth_port_pins.sv ====
/*
 * Pin-level logic of one Ethernet port: transmit lane framing on the
 * link clock, receive error and false-carrier decode, TBI code bit 9
 * capture on both byte clocks, carrier sense and MII clock generation.
 * Assumes txLinkClk is the clock of the chosen mode and that mode and
 * role inputs only change while the port is idle.
 */


module eth_port_pins
  import eth_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txLinkClk,
  input wire port_mode_t portMode,
  input wire logic phyEmulation,
  input wire logic txWordValid,
  input wire logic [TX_WORD_W-1:0] txWord,
  input wire logic txWordLast,
  output logic txWordReady,
  output logic txBusy,
  output logic txUnderrun,
  output logic rxErrorSeen,
  output logic falseCarrierSeen,
  output logic carrierSensed,
  output logic linkDetected,
  output logic codeBit9Ph0,
  output logic codeBit9Ph1,
  input wire logic port_rx_error,
  input wire logic port_rx_data_valid,
  input wire logic [TX_BUS_W-1:0] port_rx_bus,
  input wire logic port_rx_byte_clock_ph0,
  input wire logic port_rx_byte_clock_ph1,
  input wire logic port_carrier_sense_in,
  output logic port_carrier_sense_out,
  output logic port_carrier_sense_oe,
  output logic port_tx_clock_100m_out,
  output logic port_tx_clock_100m_oe,
  output logic [TX_BUS_W-1:0] port_tx_bus,
  output logic port_tx_enable
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

  localparam logic [1:0] DIV_LAST = 2'(TX_CLOCK_HALF_CYCLES - 1);

  logic [TX_WORD_W-1:0] holdWord_reg;
  logic holdLast_reg;
  logic reqTog_reg;
  logic ackTogSync;
  logic underrunTogSync;
  logic underrunSeen_reg;
  logic busySync;
  logic [1:0] divCount_reg;
  logic txClkOut_reg;
  logic crsOut_reg;
  logic rxErrPrev_reg;
  logic falsePrev_reg;
  logic rxErrorSeen_reg;
  logic falseCarrierSeen_reg;
  logic rxErrSync;
  logic rxValidSync;
  logic crsInSync;
  logic [TX_BUS_W-1:0] rxBusSync;
  logic ph0Cap_reg;
  logic ph1Cap_reg;

  tx_state_t txState_reg;
  logic [TX_BUS_W-1:0] txBus_reg;
  logic txEn_reg;
  logic [TX_WORD_W-1:0] curWord_reg;
  logic curLast_reg;
  logic [2:0] symIdx_reg;
  logic ackTog_reg;
  logic underrunTog_reg;
  logic reqTogLink;
  logic [1:0] modeLinkBits;
  logic phyEmuLink;

  // ****************************************
  // Mode decode, system side
  // ****************************************
  wire isMii = (portMode == MODE_MII);
  wire isGmii = (portMode == MODE_GMII);
  wire isRmii = (portMode == MODE_RMII);
  wire isTbi = (portMode == MODE_TBI);
  wire crsMode = isMii || isGmii;
  wire holdFree = (ackTogSync == reqTog_reg);
  wire takeWord = txWordValid && holdFree;
  wire [TX_BUS_W-1:0] fcMask = isGmii ? MASK_GMII : (isMii ? MASK_MII : MASK_RMII);
  // error only with valid
  // Valid is active high; error outside it only counts as false carrier
  wire rxErrNow = rxErrSync && rxValidSync && !isTbi;
  wire falseNow = rxErrSync && !rxValidSync && !isTbi &&
                  ((rxBusSync & fcMask) == (FALSE_CARRIER_CODE & fcMask));

  // ****************************************
  // Receive side synchronisers
  // ****************************************
  sync_2ff #(.WIDTH(TX_BUS_W + 3)) u_rx_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({port_rx_bus, port_rx_error, port_rx_data_valid, port_carrier_sense_in}),
    .q({rxBusSync, rxErrSync, rxValidSync, crsInSync})
  );

  always_ff @(posedge port_rx_byte_clock_ph0 or negedge rst_b) begin
    if (!rst_b) begin
      ph0Cap_reg <= 1'b0;
    end else begin
      ph0Cap_reg <= port_rx_error;
    end
  end

  always_ff @(posedge port_rx_byte_clock_ph1 or negedge rst_b) begin
    if (!rst_b) begin
      ph1Cap_reg <= 1'b0;
    end else begin
      ph1Cap_reg <= port_rx_error;
    end
  end

  // Byte clocks may stop, so the captured bits cross as levels
  sync_2ff #(.WIDTH(2)) u_tbi_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({ph0Cap_reg, ph1Cap_reg}),
    .q({codeBit9Ph0, codeBit9Ph1})
  );

  // ****************************************
  // Receive events
  // ****************************************
  // error pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxErrPrev_reg <= 1'b0;
      falsePrev_reg <= 1'b0;
      rxErrorSeen_reg <= 1'b0;
      falseCarrierSeen_reg <= 1'b0;
    end else begin
      rxErrPrev_reg <= rxErrNow;
      falsePrev_reg <= falseNow;
      rxErrorSeen_reg <= rxErrNow && !rxErrPrev_reg;
      falseCarrierSeen_reg <= falseNow && !falsePrev_reg;
    end
  end

  assign rxErrorSeen = rxErrorSeen_reg;
  assign falseCarrierSeen = falseCarrierSeen_reg;

  // ****************************************
  // Carrier sense and link detect
  // ****************************************
  // busy either side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crsOut_reg <= 1'b0;
    end else begin
      crsOut_reg <= crsMode && (busySync || rxValidSync);
    end
  end

  assign port_carrier_sense_out = crsOut_reg;
  assign port_carrier_sense_oe = phyEmulation && crsMode;
  assign carrierSensed = phyEmulation ? crsOut_reg : (crsMode && crsInSync);
  assign linkDetected = isTbi && crsInSync;

  // ****************************************
  // MII transmit clock generation
  // ****************************************
  // divide to 25 MHz
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount_reg <= 2'h0;
      txClkOut_reg <= 1'b0;
    end else if (divCount_reg == DIV_LAST) begin
      divCount_reg <= 2'h0;
      txClkOut_reg <= !txClkOut_reg;
    end else begin
      divCount_reg <= divCount_reg + 2'h1;
    end
  end

  assign port_tx_clock_100m_out = txClkOut_reg;
  assign port_tx_clock_100m_oe = phyEmulation && isMii;

  // ****************************************
  // Transmit word hand-over, system side
  // ****************************************
  // Single holding word; the link reads it only while the toggles differ
  // Trade-off: one word of storage, so fast modes underrun
  // Word is stable from toggle to acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      holdWord_reg <= '0;
      holdLast_reg <= 1'b0;
      reqTog_reg <= 1'b0;
    end else if (takeWord) begin
      holdWord_reg <= txWord;
      holdLast_reg <= txWordLast;
      reqTog_reg <= !reqTog_reg;
    end
  end

  assign txWordReady = holdFree;

  sync_2ff #(.WIDTH(3)) u_back_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({ackTog_reg, underrunTog_reg, txState_reg == TX_SEND}),
    .q({ackTogSync, underrunTogSync, busySync})
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      underrunSeen_reg <= 1'b0;
    end else begin
      underrunSeen_reg <= underrunTogSync;
    end
  end

  assign txUnderrun = underrunTogSync ^ underrunSeen_reg;
  assign txBusy = busySync;

  // ****************************************
  // Link domain
  // ****************************************
  // static mode into link domain
  sync_2ff #(.WIDTH(4)) u_link_sync (
    .clk(txLinkClk),
    .rst_b(rst_b),
    .d({reqTog_reg, portMode, phyEmulation}),
    .q({reqTogLink, modeLinkBits, phyEmuLink})
  );

  wire port_mode_t modeLink = port_mode_t'(modeLinkBits);
  wire tbiLink = (modeLink == MODE_TBI);
  wire [2:0] symsPerWord = (modeLink == MODE_MII) ? SYMS_MII :
                           ((modeLink == MODE_RMII) ? SYMS_RMII : SYMS_GMII);
  wire wordAvail = (reqTogLink != ackTog_reg);
  wire wordDone = (symIdx_reg == symsPerWord);
  wire loadNext = (txState_reg == TX_IDLE || (wordDone && !curLast_reg)) && wordAvail;
  wire underrunNow = (txState_reg == TX_SEND) && wordDone && !curLast_reg && !wordAvail;
  wire [TX_WORD_W-1:0] srcWord = loadNext ? holdWord_reg : curWord_reg;
  wire [2:0] srcIdx = loadNext ? 3'h0 : symIdx_reg;
  wire [3:0] miiLane = srcWord[4*srcIdx[0] +: MII_LANE_W];
  wire [1:0] rmiiLane = srcWord[2*srcIdx[1:0] +: RMII_LANE_W];
  wire [TX_BUS_W-1:0] symbol = (modeLink == MODE_MII) ? {4'h0, miiLane} :
                               ((modeLink == MODE_RMII) ? {6'h00, rmiiLane} :
                               srcWord[TX_BUS_W-1:0]);
  wire sendSym = loadNext || (txState_reg == TX_SEND && !wordDone);
  // bit 8 in TBI, enable otherwise
  wire enNext = tbiLink ? srcWord[TBI_ENABLE_BIT] : 1'b1;

  always_ff @(posedge txLinkClk or negedge rst_b) begin
    if (!rst_b) begin
      txBus_reg <= '0;
      txEn_reg <= 1'b0;
    end else if (sendSym) begin
      txBus_reg <= symbol;
      txEn_reg <= enNext;
    end else if (txState_reg == TX_SEND && wordDone) begin
      txBus_reg <= '0;
      txEn_reg <= 1'b0;
    end
  end

  always_ff @(posedge txLinkClk or negedge rst_b) begin
    if (!rst_b) begin
      txState_reg <= TX_IDLE;
      curWord_reg <= '0;
      curLast_reg <= 1'b0;
      symIdx_reg <= 3'h0;
      ackTog_reg <= 1'b0;
      underrunTog_reg <= 1'b0;
    end else begin
      case (txState_reg)
        TX_IDLE: begin
          if (wordAvail) begin
            txState_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (wordDone && (curLast_reg || !wordAvail)) begin
            txState_reg <= TX_IDLE;
          end
        end
        default: begin
          txState_reg <= TX_IDLE;
        end
      endcase
      if (loadNext) begin
        curWord_reg <= holdWord_reg;
        curLast_reg <= holdLast_reg;
        symIdx_reg <= 3'h1;
        ackTog_reg <= !ackTog_reg;
      end else if (sendSym) begin
        symIdx_reg <= symIdx_reg + 3'h1;
      end
      // Source too slow: the frame is cut rather than stretched
      if (underrunNow) begin
        underrunTog_reg <= !underrunTog_reg;
      end
    end
  end

  assign port_tx_bus = txBus_reg;
  assign port_tx_enable = txEn_reg;

  // PHY emulation role is not used on the link side beyond the clock loop
  wire unusedLink = phyEmuLink;

endmodule : eth_port_pins

// ==== bench/eth_port_pins_properties.sv ====
/* Checker for the Ethernet port pin block, watching top-level ports only.
   Assumes mode and role change only while reset is held. */
module eth_port_pins_properties
  import eth_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txLinkClk,
  input wire port_mode_t portMode,
  input wire logic phyEmulation,
  input wire logic port_rx_error,
  input wire logic port_rx_data_valid,
  input wire logic rxErrorSeen,
  input wire logic falseCarrierSeen,
  input wire logic linkDetected,
  input wire logic port_carrier_sense_oe,
  input wire logic port_tx_clock_100m_out,
  input wire logic port_tx_clock_100m_oe,
  input wire logic [TX_BUS_W-1:0] port_tx_bus
);
  // ****************************************
  // Properties
  // ****************************************
  sequence s_clkHigh;
    port_tx_clock_100m_out [*2];
  endsequence
  sequence s_clkLow;
    !port_tx_clock_100m_out [*2];
  endsequence
  property p_clkWave;
    @(posedge clk) disable iff (!rst_b)
      port_tx_clock_100m_oe && $rose(port_tx_clock_100m_out) |-> s_clkHigh ##1 s_clkLow ##1 port_tx_clock_100m_out;
  endproperty
  a_clkWave: assert property (p_clkWave) else $error("tx clock not clk/4");
  property p_clkOe;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |-> ##2 (port_tx_clock_100m_oe == (phyEmulation && portMode == MODE_MII));
  endproperty
  a_clkOe: assert property (p_clkOe) else $error("tx clock direction wrong");
  property p_csOe;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |-> ##2 (port_carrier_sense_oe ==
        (phyEmulation && (portMode == MODE_MII || portMode == MODE_GMII)));
  endproperty
  a_csOe: assert property (p_csOe) else $error("carrier sense direction wrong");
  property p_miiLanes;
    @(posedge txLinkClk) disable iff (!rst_b)
      portMode == MODE_MII |-> port_tx_bus[7:4] == 4'h0;
  endproperty
  a_miiLanes: assert property (p_miiLanes) else $error("upper lanes used in MII");
  property p_rmiiLanes;
    @(posedge txLinkClk) disable iff (!rst_b)
      portMode == MODE_RMII |-> port_tx_bus[7:2] == 6'h00;
  endproperty
  a_rmiiLanes: assert property (p_rmiiLanes) else $error("upper lanes used in RMII");
  property p_rxErr;
    @(posedge clk) disable iff (!rst_b)
      rxErrorSeen |-> portMode != MODE_TBI && $past(port_rx_error, 3) && $past(port_rx_data_valid, 3);
  endproperty
  a_rxErr: assert property (p_rxErr) else $error("error flag without cause");
  property p_falseCarrier;
    @(posedge clk) disable iff (!rst_b)
      falseCarrierSeen |-> portMode != MODE_TBI && $past(port_rx_error, 3) && !$past(port_rx_data_valid, 3);
  endproperty
  a_falseCarrier: assert property (p_falseCarrier) else $error("false carrier without cause");
  property p_linkTbi;
    @(posedge clk) disable iff (!rst_b)
      linkDetected |-> portMode == MODE_TBI;
  endproperty
  a_linkTbi: assert property (p_linkTbi) else $error("link detect outside TBI");
endmodule : eth_port_pins_properties

bind eth_port_pins eth_port_pins_properties u_eth_port_pins_properties (.clk, .rst_b, .txLinkClk,
  .portMode, .phyEmulation, .port_rx_error, .port_rx_data_valid, .rxErrorSeen,
  .falseCarrierSeen, .linkDetected, .port_carrier_sense_oe, .port_tx_clock_100m_out,
  .port_tx_clock_100m_oe, .port_tx_bus);

// ==== bench/eth_phy_model.sv ====
/* Far-side PHY model: drives receive pins, carrier sense and byte clocks,
   and records transmit symbols. Assumes the bench supplies the link clock. */
module eth_phy_model
  import eth_port_pkg::*;
(
  input wire logic txLinkClk,
  input wire port_mode_t portMode,
  input wire logic [TX_BUS_W-1:0] port_tx_bus,
  input wire logic port_tx_enable,
  output logic port_rx_error,
  output logic port_rx_data_valid,
  output logic [TX_BUS_W-1:0] port_rx_bus,
  output logic port_rx_byte_clock_ph0,
  output logic port_rx_byte_clock_ph1,
  output logic phyCarrier
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [TX_WORD_W-1:0] got[$];
  int frames = 0;
  logic enPrev = 1'b0;
  initial begin
    {port_rx_error, port_rx_data_valid, port_rx_bus, phyCarrier} = '0;
    {port_rx_byte_clock_ph0, port_rx_byte_clock_ph1} = 2'h0;
  end
  task automatic rxDrive(input logic err, input logic dv, input logic [7:0] d, input logic cs);
    port_rx_error <= err;
    port_rx_data_valid <= dv;
    port_rx_bus <= d;
    phyCarrier <= cs;
  endtask : rxDrive
  task automatic byteClocks;
    #8 port_rx_byte_clock_ph0 = 1'b1;
    #8 port_rx_byte_clock_ph0 = 1'b0;
    #8 port_rx_byte_clock_ph1 = 1'b1;
    #8 port_rx_byte_clock_ph1 = 1'b0;
  endtask : byteClocks
  always @(posedge txLinkClk) begin
    if (portMode == MODE_TBI) begin
      if ({port_tx_enable, port_tx_bus} != 9'h000) got.push_back({port_tx_enable, port_tx_bus});
    end else if (port_tx_enable === 1'b1) begin
      got.push_back({1'b1, port_tx_bus});
    end
    if (port_tx_enable === 1'b1 && !enPrev) frames++;
    enPrev <= port_tx_enable;
  end
endmodule : eth_phy_model

// ==== bench/tb_eth_port_pins.sv ====
/* Self-checking bench for the Ethernet port pin block.
   Assumes the PHY model on the far side and a free 32 ns link clock. */
module tb_eth_port_pins;
  import eth_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, linkClk = 0, rst_b = 0, phyEmulation = 0;
  port_mode_t portMode = MODE_MII;
  logic txWordValid = 0, txWordLast = 0;
  logic [TX_WORD_W-1:0] txWord = '0, exp[$];
  logic txWordReady, rxErrorSeen, falseCarrierSeen, carrierSensed, linkDetected;
  logic codeBit9Ph0, codeBit9Ph1, rxErr, rxDv, ph0, ph1, phyCs, csOut, csOe, tcOut, tcOe, txEn;
  logic [7:0] rxBus, txBus;
  wire logic linkMux = tcOe ? tcOut : linkClk;
  wire logic csPin = csOe ? csOut : phyCs;
  int err_count = 0, cmp_count = 0, cyc = 0, rxCnt = 0, fcCnt = 0;
  always #5 clk = ~clk;
  always #16 linkClk = ~linkClk;
  eth_port_pins u_eth_port_pins (.clk, .rst_b, .txLinkClk(linkMux), .portMode, .phyEmulation,
    .txWordValid, .txWord, .txWordLast, .txWordReady, .txBusy(), .txUnderrun(), .rxErrorSeen,
    .falseCarrierSeen, .carrierSensed, .linkDetected, .codeBit9Ph0, .codeBit9Ph1,
    .port_rx_error(rxErr), .port_rx_data_valid(rxDv), .port_rx_bus(rxBus),
    .port_rx_byte_clock_ph0(ph0), .port_rx_byte_clock_ph1(ph1), .port_carrier_sense_in(csPin),
    .port_carrier_sense_out(csOut), .port_carrier_sense_oe(csOe),
    .port_tx_clock_100m_out(tcOut), .port_tx_clock_100m_oe(tcOe), .port_tx_bus(txBus),
    .port_tx_enable(txEn));
  eth_phy_model u_eth_phy_model (.txLinkClk(linkMux), .portMode, .port_tx_bus(txBus),
    .port_tx_enable(txEn), .port_rx_error(rxErr), .port_rx_data_valid(rxDv),
    .port_rx_bus(rxBus), .port_rx_byte_clock_ph0(ph0), .port_rx_byte_clock_ph1(ph1),
    .phyCarrier(phyCs));
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic close_out;
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (rxErrorSeen === 1'b1) rxCnt++;
    if (falseCarrierSeen === 1'b1) fcCnt++;
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end
  // ****************************************
  // Stimulus
  // ****************************************
  // Expected lane order, low lane first
  task automatic pushExp(input port_mode_t m, input logic [8:0] w);
    int lw;
    lw = (m == MODE_MII) ? MII_LANE_W : (m == MODE_RMII) ? RMII_LANE_W : 8;
    if (m == MODE_TBI) exp.push_back(w);
    else for (int k = 0; k < 8 / lw; k++) exp.push_back({1'b1, (w[7:0] >> (k * lw)) & 8'((1 << lw) - 1)});
  endtask : pushExp
  task automatic send(input logic [8:0] w, input logic last);
    txWordValid <= 1'b1;
    txWord <= w;
    txWordLast <= last;
    do @(negedge clk); while (txWordReady !== 1'b1);
    @(posedge clk);
  endtask : send
  task automatic runMode(input port_mode_t m, input logic pe);
    logic [8:0] w;
    logic [7:0] mask;
    int f0, nw, n;
    mask = (m == MODE_GMII) ? MASK_GMII : (m == MODE_MII) ? MASK_MII : MASK_RMII;
    @(posedge clk);
    rst_b <= 1'b0;
    portMode <= m;
    phyEmulation <= pe;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    exp.delete();
    u_eth_phy_model.got.delete();
    f0 = u_eth_phy_model.frames;
    // Back-to-back words in RMII, one-word packets elsewhere
    nw = (m == MODE_RMII) ? 2 : 1;
    for (int i = 0; i < nw; i++) begin
      w = 9'($urandom) | 9'h001;
      pushExp(m, w);
      send(w, i == nw - 1);
    end
    txWordValid <= 1'b0;
    n = 0;
    while (u_eth_phy_model.got.size() < exp.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check("symbol count", u_eth_phy_model.got.size(), exp.size());
    foreach (exp[i]) check("tx symbol", u_eth_phy_model.got[i], exp[i]);
    if (m != MODE_TBI) check("frames", u_eth_phy_model.frames - f0, 1);
    if (m == MODE_TBI) begin
      u_eth_phy_model.rxDrive(1'b1, 1'b0, 8'h00, 1'b1);
      @(posedge clk);
      u_eth_phy_model.byteClocks();
      repeat (8) @(posedge clk);
      check("link detect", linkDetected, 1);
      check("bit9 ph0", codeBit9Ph0, 1);
      check("bit9 ph1", codeBit9Ph1, 1);
    end else begin
      n = rxCnt;
      u_eth_phy_model.rxDrive(1'b1, 1'b1, 8'($urandom), 1'b1);
      repeat (8) @(posedge clk);
      check("rx error", rxCnt, n + 1);
      if (!pe && m != MODE_RMII) check("carrier", carrierSensed, 1);
      n = fcCnt;
      f0 = rxCnt;
      u_eth_phy_model.rxDrive(1'b1, 1'b0, FALSE_CARRIER_CODE | (8'($urandom) & ~mask), 1'b0);
      repeat (8) @(posedge clk);
      check("false carrier", fcCnt, n + 1);
      check("rx error held", rxCnt, f0);
    end
    u_eth_phy_model.rxDrive(1'b0, 1'b0, 8'h00, 1'b0);
    repeat (8) @(posedge clk);
  endtask : runMode
  initial begin
    void'($urandom(15));
    runMode(MODE_MII, 1'b0);
    runMode(MODE_GMII, 1'b0);
    runMode(MODE_RMII, 1'b0);
    runMode(MODE_TBI, 1'b0);
    runMode(MODE_MII, 1'b1);
    close_out();
  end
endmodule : tb_eth_port_pins
